// ### rtl/pmlock_pkg.sv
/*
  Package for the program memory lock and encryption block: register map,
  field positions, reset values, mode encodings and the pin carrier struct.
  Assumes a 32-bit APB slave at 100 MHz.
*/
package pmlock_pkg;
  localparam int unsigned PMLOCK_ADDR_W = 13;
  localparam int unsigned PMLOCK_ENC_N = 32;
  localparam int unsigned PMLOCK_ENC_W = 5;
  // Register byte offsets
  localparam logic [11:0] PMLOCK_CTRL_OFS = 12'h000;
  localparam logic [11:0] PMLOCK_STAT_OFS = 12'h004;
  localparam logic [11:0] PMLOCK_ADDR_OFS = 12'h008;
  localparam logic [11:0] PMLOCK_DATA_OFS = 12'h00c;
  // Control fields
  localparam int unsigned PMLOCK_CTRL_ERASE_BIT = 0;
  localparam int unsigned PMLOCK_CTRL_RDEN_BIT = 1;
  // Status fields
  localparam int unsigned PMLOCK_STAT_LB1_BIT = 0;
  localparam int unsigned PMLOCK_STAT_LB2_BIT = 1;
  localparam int unsigned PMLOCK_STAT_EA_BIT = 2;
  localparam int unsigned PMLOCK_STAT_BUSY_BIT = 3;
  localparam int unsigned PMLOCK_STAT_REFUSE_BIT = 4;
  localparam logic [7:0] PMLOCK_ERASED_BYTE = 8'hff;
  localparam logic [7:0] PMLOCK_FLOAT_BYTE = 8'hff;
  localparam logic [15:0] PMLOCK_SIG_MAKER_ADDR = 16'h0030;
  localparam logic [15:0] PMLOCK_SIG_PART_ADDR = 16'h0031;
  // Strobe pulse time and cycle count at 100 MHz
  localparam int unsigned PMLOCK_CLK_MHZ = 100;
  localparam int unsigned PMLOCK_PROG_MIN_NS = 90000;
  localparam int unsigned PMLOCK_PROG_CYC = (PMLOCK_PROG_MIN_NS * PMLOCK_CLK_MHZ + 999) / 1000;
  localparam logic [31:0] PMLOCK_APB_ERR_DATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    PMLOCK_MODE_IDLE = 3'b000,
    PMLOCK_MODE_PROG_CODE = 3'b001,
    PMLOCK_MODE_VERIFY = 3'b010,
    PMLOCK_MODE_PROG_ENC = 3'b011,
    PMLOCK_MODE_PROG_LB1 = 3'b100,
    PMLOCK_MODE_PROG_LB2 = 3'b101,
    PMLOCK_MODE_SIG = 3'b110
  } pmlock_mode_t;

  typedef struct packed {
    logic program_strobe_n;
    logic verify_enable_pin;
    logic mode_lock_pin;
    logic sig_select_a;
    logic sig_select_b;
    logic [15:0] addr;
    logic [7:0] data;
  } pmlock_pins_t;
endpackage : pmlock_pkg

// ### rtl/pmlock_mem.sv
/*
  Simple dual-port byte memory (separate write and read address) with registered read data.
  Assumes writes and reads come from one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pmlock_mem #(
  parameter int unsigned AW = 13
) (
  input wire logic pclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk) begin
    rdata <= mem[raddr];
  end
endmodule : pmlock_mem
`default_nettype wire

// ### rtl/pmlock_top.sv
/*
  Program memory lock and encryption: code array, 32-byte encryption array,
  two lock bits, external access latch, signature readout and an APB
  register port for erase and internal table reads.
  Assumes programmer pins arrive asynchronously and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Keep a 32-byte encryption array reading all ones until programmed.
// - Pick the encryption byte from five address lines on each verify.
// - Verify output is code XNOR encryption byte; ones leave code unchanged.
// - Erase returns code and encryption array to all ones and clears both lock bits.
// - Both lock bits clear: minimum protection, verify still encrypted.
// - Lock one set: table reads fetched externally cannot read internal code.
// - Lock one set: external access pin latched at reset, pin then ignored.
// - Lock one set: further programming of code memory is refused.
// - Both lock bits set: also disable verify readout.
// - Lock two without lock one is reserved; treat it as no lock here.
// - Signature bytes read at 030H and 031H with both selects low.
// - Verify takes address on the address pins and drives data on port 0.
module pmlock_top #(
  parameter int unsigned ADDR_W = pmlock_pkg::PMLOCK_ADDR_W,
  parameter int unsigned PROG_CYC = pmlock_pkg::PMLOCK_PROG_CYC,
  parameter logic [7:0] SIG_MAKER = 8'h5a, // Arbitrary value
  parameter logic [7:0] SIG_PART = 8'h3c // Arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pmlock_pkg::pmlock_pins_t pins_in,
  input wire logic external_access_pin,
  input wire logic table_read_from_ext,
  output logic [7:0] port0_out,
  output logic port0_oe,
  output logic external_access_eff
);
  initial begin
    if (ADDR_W < 6 || ADDR_W > 16) $error("pmlock_top: ADDR_W out of range");
    if (PROG_CYC < 2) $error("pmlock_top: PROG_CYC too small");
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  pmlock_pkg::pmlock_pins_t pins_s1_q, pins_q;
  logic ea_s1_q, ea_q;

  always_ff @(posedge pclk) begin // Unreset so the latch sees the pin at reset release
    ea_s1_q <= external_access_pin;
    ea_q <= ea_s1_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_s1_q <= '1;
      pins_q <= '1;
    end else begin
      pins_s1_q <= pins_in;
      pins_q <= pins_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  function automatic pmlock_pkg::pmlock_mode_t mode_of(input pmlock_pkg::pmlock_pins_t p);
    logic [3:0] sel;
    sel = {p.verify_enable_pin, p.mode_lock_pin, p.sig_select_a, p.sig_select_b};
    case (sel)
      4'b1011: mode_of = pmlock_pkg::PMLOCK_MODE_PROG_CODE;
      4'b0011: mode_of = pmlock_pkg::PMLOCK_MODE_VERIFY;
      4'b1001: mode_of = pmlock_pkg::PMLOCK_MODE_PROG_ENC;
      4'b1111: mode_of = pmlock_pkg::PMLOCK_MODE_PROG_LB1;
      4'b1100: mode_of = pmlock_pkg::PMLOCK_MODE_PROG_LB2;
      4'b0000: mode_of = pmlock_pkg::PMLOCK_MODE_SIG;
      default: mode_of = pmlock_pkg::PMLOCK_MODE_IDLE;
    endcase
  endfunction : mode_of

  function automatic logic [7:0] xnor_byte(input logic [7:0] a, input logic [7:0] b);
    xnor_byte = ~(a ^ b);
  endfunction : xnor_byte

  pmlock_pkg::pmlock_mode_t mode;
  assign mode = mode_of(pins_q);

  // ---------------------------------------------------------------
  // Lock state
  // ---------------------------------------------------------------
  logic lock_bit_one_q, lock_bit_two_q;
  logic lock_one, lock_two;
  logic erase_req;
  logic prog_fire;
  logic refuse_q;

  // Reserved combination gets no extra restriction; lock two only counts with lock one
  assign lock_one = lock_bit_one_q;
  assign lock_two = lock_bit_one_q & lock_bit_two_q;

  // Lock bits are nonvolatile in the part; reset is modelled as erased state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_bit_one_q <= 1'b0;
      lock_bit_two_q <= 1'b0;
    end else if (erase_req) begin
      lock_bit_one_q <= 1'b0;
      lock_bit_two_q <= 1'b0;
    end else if (prog_fire && mode == pmlock_pkg::PMLOCK_MODE_PROG_LB1) begin
      lock_bit_one_q <= 1'b1;
    end else if (prog_fire && mode == pmlock_pkg::PMLOCK_MODE_PROG_LB2) begin
      lock_bit_two_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // External access latch
  // ---------------------------------------------------------------
  logic rst_seen_q, ea_latched_q;

  // Captured on the first clock after reset release, never in reset itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_seen_q <= 1'b0;
      ea_latched_q <= 1'b0;
    end else if (!rst_seen_q) begin
      rst_seen_q <= 1'b1;
      ea_latched_q <= ea_q;
    end
  end

  assign external_access_eff = lock_one ? ea_latched_q : ea_q;

  // ---------------------------------------------------------------
  // Program strobe width
  // ---------------------------------------------------------------
  logic [$clog2(PROG_CYC+1)-1:0] pulse_cnt_q;
  logic strobe_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt_q <= '0;
      strobe_prev_q <= 1'b1;
    end else begin
      strobe_prev_q <= pins_q.program_strobe_n;
      if (pins_q.program_strobe_n) begin
        pulse_cnt_q <= '0;
      end else if (pulse_cnt_q != PROG_CYC[$clog2(PROG_CYC+1)-1:0]) begin
        pulse_cnt_q <= pulse_cnt_q + 1'b1;
      end
    end
  end

  // A write lands on the rising strobe edge once the low time was long enough
  assign prog_fire = pins_q.program_strobe_n && !strobe_prev_q
                     && pulse_cnt_q == PROG_CYC[$clog2(PROG_CYC+1)-1:0];

  // ---------------------------------------------------------------
  // Encryption array
  // ---------------------------------------------------------------
  logic [7:0] enc_q [0:pmlock_pkg::PMLOCK_ENC_N-1];
  logic [pmlock_pkg::PMLOCK_ENC_W-1:0] enc_idx;
  assign enc_idx = pins_q.addr[pmlock_pkg::PMLOCK_ENC_W-1:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < pmlock_pkg::PMLOCK_ENC_N; i++) begin
        enc_q[i] <= pmlock_pkg::PMLOCK_ERASED_BYTE;
      end
    end else if (erase_req) begin
      for (int i = 0; i < pmlock_pkg::PMLOCK_ENC_N; i++) begin
        enc_q[i] <= pmlock_pkg::PMLOCK_ERASED_BYTE;
      end
    end else if (prog_fire && mode == pmlock_pkg::PMLOCK_MODE_PROG_ENC && !lock_one) begin
      // Programming only clears bits, as in a floating gate cell
      enc_q[enc_idx] <= enc_q[enc_idx] & pins_q.data;
    end
  end

  // ---------------------------------------------------------------
  // Code memory and erase sweep
  // ---------------------------------------------------------------
  logic erasing_q;
  logic [ADDR_W-1:0] erase_ptr_q;
  logic mem_we;
  logic [ADDR_W-1:0] mem_waddr, mem_raddr, tbl_addr_q;
  logic [7:0] mem_wdata, mem_rdata;
  logic tbl_sel_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      erasing_q <= 1'b0;
      erase_ptr_q <= '0;
    end else if (erase_req) begin
      erasing_q <= 1'b1;
      erase_ptr_q <= '0;
    end else if (erasing_q) begin
      erase_ptr_q <= erase_ptr_q + 1'b1;
      if (&erase_ptr_q) begin
        erasing_q <= 1'b0;
      end
    end
  end

  logic code_prog;
  assign code_prog = prog_fire && mode == pmlock_pkg::PMLOCK_MODE_PROG_CODE;

  assign mem_we = erasing_q | (code_prog & !lock_one);
  assign mem_waddr = erasing_q ? erase_ptr_q : pins_q.addr[ADDR_W-1:0];
  assign mem_wdata = erasing_q ? pmlock_pkg::PMLOCK_ERASED_BYTE : pins_q.data;
  assign mem_raddr = tbl_sel_q ? tbl_addr_q : pins_q.addr[ADDR_W-1:0];

  pmlock_mem #(
    .AW(ADDR_W)
  ) u_mem (
    .pclk(pclk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refuse_q <= 1'b0;
    end else if ((code_prog || (prog_fire && mode == pmlock_pkg::PMLOCK_MODE_PROG_ENC))
                 && lock_one) begin
      refuse_q <= 1'b1;
    end else if (erase_req) begin
      refuse_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Verify and signature readout on port 0
  // ---------------------------------------------------------------
  logic [7:0] enc_sel_q;
  logic read_mode_q, sig_mode_q;
  logic [15:0] addr_d1_q;

  // Encryption byte and mode are delayed to line up with the memory read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enc_sel_q <= pmlock_pkg::PMLOCK_ERASED_BYTE;
      read_mode_q <= 1'b0;
      sig_mode_q <= 1'b0;
      addr_d1_q <= '0;
    end else begin
      enc_sel_q <= enc_q[enc_idx];
      read_mode_q <= mode == pmlock_pkg::PMLOCK_MODE_VERIFY && !tbl_sel_q;
      sig_mode_q <= mode == pmlock_pkg::PMLOCK_MODE_SIG;
      addr_d1_q <= pins_q.addr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port0_out <= pmlock_pkg::PMLOCK_FLOAT_BYTE;
      port0_oe <= 1'b0;
    end else if (sig_mode_q) begin
      port0_oe <= 1'b1;
      if (addr_d1_q == pmlock_pkg::PMLOCK_SIG_MAKER_ADDR) begin
        port0_out <= SIG_MAKER;
      end else if (addr_d1_q == pmlock_pkg::PMLOCK_SIG_PART_ADDR) begin
        port0_out <= SIG_PART;
      end else begin
        port0_out <= pmlock_pkg::PMLOCK_FLOAT_BYTE;
      end
    end else if (read_mode_q && !lock_two && !erasing_q) begin
      port0_oe <= 1'b1;
      port0_out <= xnor_byte(mem_rdata, enc_sel_q);
    end else begin
      port0_oe <= 1'b0;
      port0_out <= pmlock_pkg::PMLOCK_FLOAT_BYTE;
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  logic apb_acc, apb_wr, apb_rd;
  logic [1:0] tbl_wait_q;
  logic tbl_blocked_q, tbl_done_q;
  logic [7:0] tbl_data_q;
  logic mapped;

  assign apb_acc = psel & penable;
  assign apb_wr = apb_acc & pwrite;
  assign apb_rd = apb_acc & !pwrite;
  assign mapped = paddr == pmlock_pkg::PMLOCK_CTRL_OFS || paddr == pmlock_pkg::PMLOCK_STAT_OFS
                  || paddr == pmlock_pkg::PMLOCK_ADDR_OFS || paddr == pmlock_pkg::PMLOCK_DATA_OFS;
  assign erase_req = apb_wr && pready && paddr == pmlock_pkg::PMLOCK_CTRL_OFS
                     && pwdata[pmlock_pkg::PMLOCK_CTRL_ERASE_BIT];

  // Table reads stall three cycles for the memory's registered read port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_addr_q <= '0;
      tbl_sel_q <= 1'b0;
      tbl_wait_q <= 2'h0;
      tbl_blocked_q <= 1'b0;
      tbl_data_q <= 8'h00;
    end else begin
      if (apb_wr && pready && paddr == pmlock_pkg::PMLOCK_ADDR_OFS) begin
        tbl_addr_q <= pwdata[ADDR_W-1:0];
      end
      if (apb_rd && paddr == pmlock_pkg::PMLOCK_DATA_OFS && !tbl_sel_q && !tbl_done_q) begin
        tbl_sel_q <= 1'b1;
        tbl_wait_q <= 2'h2;
        tbl_blocked_q <= table_read_from_ext && lock_one;
      end else if (tbl_wait_q != 2'h0) begin
        tbl_wait_q <= tbl_wait_q - 2'h1;
        if (tbl_wait_q == 2'h1) begin
          tbl_sel_q <= 1'b0;
          tbl_data_q <= tbl_blocked_q ? 8'h00 : mem_rdata;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_done_q <= 1'b0;
    end else begin
      tbl_done_q <= tbl_wait_q == 2'h1;
    end
  end

  always_comb begin
    pready = 1'b1;
    if (apb_rd && paddr == pmlock_pkg::PMLOCK_DATA_OFS && !tbl_done_q) begin
      pready = 1'b0;
    end
  end
  assign pslverr = apb_acc & pready & !mapped;

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[pmlock_pkg::PMLOCK_STAT_LB1_BIT] = lock_bit_one_q;
    status_word[pmlock_pkg::PMLOCK_STAT_LB2_BIT] = lock_bit_two_q;
    status_word[pmlock_pkg::PMLOCK_STAT_EA_BIT] = external_access_eff;
    status_word[pmlock_pkg::PMLOCK_STAT_BUSY_BIT] = erasing_q;
    status_word[pmlock_pkg::PMLOCK_STAT_REFUSE_BIT] = refuse_q;
  end

  always_comb begin
    prdata = pmlock_pkg::PMLOCK_APB_ERR_DATA;
    if (apb_rd && pready) begin
      case (paddr)
        pmlock_pkg::PMLOCK_STAT_OFS: prdata = status_word;
        pmlock_pkg::PMLOCK_ADDR_OFS: prdata = {{(32-ADDR_W){1'b0}}, tbl_addr_q};
        pmlock_pkg::PMLOCK_DATA_OFS: prdata = {24'h000000, tbl_data_q};
        default: prdata = pmlock_pkg::PMLOCK_APB_ERR_DATA;
      endcase
    end
  end
endmodule : pmlock_top
`default_nettype wire

// ### dv/pmlock_top_chk.sv
/*
  Checker for the lock and encryption block: APB answer timing and pin-side
  readout relations.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module pmlock_top_chk #(
  parameter logic [7:0] SIG_MAKER = 8'h5a,
  parameter logic [7:0] SIG_PART = 8'h3c
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire pmlock_pkg::pmlock_pins_t pins_in,
  input wire logic external_access_pin,
  input wire logic table_read_from_ext,
  input wire logic [7:0] port0_out,
  input wire logic port0_oe,
  input wire logic external_access_eff
);
  // ------
  // Properties
  // ------
  localparam logic [11:0] DOFS = pmlock_pkg::PMLOCK_DATA_OFS;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rdata_idle;
    !(psel && penable && pready) |-> prdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside a transfer");
  property p_unmapped;
    psel && penable && paddr >= 12'h010 |-> pslverr && pready && prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_wait_cause;
    !pready |-> psel && penable && !pwrite && paddr == DOFS;
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("wait state without a data read");
  property p_data_wait;
    psel && $rose(penable) && !pwrite && paddr == DOFS |-> !pready [*3] ##1 pready;
  endproperty
  a_data_wait: assert property (p_data_wait) else $error("data read wait not three cycles");
  property p_ready_bound;
    psel && penable |-> ##[0:3] pready;
  endproperty
  a_ready_bound: assert property (p_ready_bound) else $error("transfer never answered");
  // Output driven only after the enable pin has been low through the sync path
  property p_oe_mode;
    port0_oe |-> !$past(pins_in.verify_enable_pin, 2) || !$past(pins_in.verify_enable_pin, 3)
      || !$past(pins_in.verify_enable_pin, 4);
  endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("port driven outside verify");
  property p_sig;
    $stable(pins_in) [*6] ##0 (port0_oe && pins_in.addr[15:1] == 15'h0018
      && !pins_in.sig_select_a && !pins_in.sig_select_b)
      |-> port0_out == (pins_in.addr[0] ? SIG_PART : SIG_MAKER);
  endproperty
  a_sig: assert property (p_sig) else $error("wrong signature byte");
  property p_ea;
    $changed(external_access_eff) |-> external_access_eff == $past(external_access_pin, 2)
      || external_access_eff == $past(external_access_pin, 3);
  endproperty
  a_ea: assert property (p_ea) else $error("access level moved without the pin");
endmodule : pmlock_top_chk

bind pmlock_top pmlock_top_chk #(.SIG_MAKER(SIG_MAKER), .SIG_PART(SIG_PART)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pins_in(pins_in), .external_access_pin(external_access_pin),
  .table_read_from_ext(table_read_from_ext), .port0_out(port0_out), .port0_oe(port0_oe),
  .external_access_eff(external_access_eff)
);
`default_nettype wire

// ### dv/pmlock_prog_model.sv
/*
  Programmer model: drives mode, address, data and strobe pins.
  Assumes port 0 has external pull-ups and the bench calls its tasks.
*/
`timescale 1ns/1ps
`default_nettype none
module pmlock_prog_model #(
  parameter int unsigned PROG_CYC = 4,
  parameter int unsigned N_PULSE = 2
) (
  input wire logic pclk,
  output var pmlock_pkg::pmlock_pins_t pins,
  input wire logic [7:0] port0_out,
  input wire logic port0_oe
);
  // ------
  // Mode levels: enable, lock select, select a, select b
  // ------
  localparam logic [3:0] M_CODE = 4'b1011;
  localparam logic [3:0] M_VER = 4'b0011;
  localparam logic [3:0] M_ENC = 4'b1001;
  localparam logic [3:0] M_LB1 = 4'b1111;
  localparam logic [3:0] M_LB2 = 4'b1100;
  localparam logic [3:0] M_SIG = 4'b0000;
  logic [7:0] port0_level;
  // Released port reads high through the pull-ups
  assign port0_level = port0_oe ? port0_out : 8'hff;
  initial begin
    pins = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0000, 8'h00};
  end
  task automatic set_mode(input logic [3:0] m, input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    pins <= '{1'b1, m[3], m[2], m[1], m[0], a, d};
  endtask : set_mode
  // Fewer pulses than the full count: a programmed bit stays programmed
  task automatic prog_op(input logic [3:0] m, input logic [15:0] a, input logic [7:0] d);
    set_mode(m, a, d);
    repeat (N_PULSE) begin
      repeat (3) @(posedge pclk);
      pins.program_strobe_n <= 1'b0;
      repeat (PROG_CYC + 1) @(posedge pclk);
      pins.program_strobe_n <= 1'b1;
    end
    repeat (3) @(posedge pclk);
    set_mode(M_CODE, a, ~d);
  endtask : prog_op
  task automatic read_back(input logic [3:0] m, input logic [15:0] a, output logic [7:0] q,
      output logic oe);
    set_mode(m, a, ~pins.data);
    repeat (8) @(posedge pclk);
    q = port0_level;
    oe = port0_oe;
    set_mode(M_CODE, a, ~pins.data);
  endtask : read_back
endmodule : pmlock_prog_model
`default_nettype wire

// ### dv/test_pmlock_top.sv
/*
  Self-checking bench: APB master, programmer model and one task a scenario.
  Assumes the block is built with a short strobe count and small code array.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module test_pmlock_top;
  // ------
  // Setup
  // ------
  localparam int unsigned PCYC = 4;
  localparam logic [7:0] SIGM = 8'h5a; // Arbitrary value
  localparam logic [7:0] SIGP = 8'h3c; // Arbitrary value
  logic pclk, presetn, psel, penable, pwrite, ea_pin, tr_ext, err, oe;
  logic pready, pslverr, port0_oe, ea_eff;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] port0_out, q;
  pmlock_pkg::pmlock_pins_t pins;
  int n_fail, n_tests;
  pmlock_top #(.ADDR_W(8), .PROG_CYC(PCYC), .SIG_MAKER(SIGM), .SIG_PART(SIGP)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_in(pins), .external_access_pin(ea_pin), .table_read_from_ext(tr_ext),
    .port0_out(port0_out), .port0_oe(port0_oe), .external_access_eff(ea_eff));
  pmlock_prog_model #(.PROG_CYC(PCYC)) u_prog (.pclk(pclk), .pins(pins),
    .port0_out(port0_out), .port0_oe(port0_oe));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic vfy(input logic [3:0] m, input logic [15:0] a);
    u_prog.read_back(m, a, q, oe);
  endtask : vfy
  // ------
  // Scenarios
  // ------
  task automatic t_bus();
    apb(1'b0, 12'h010, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, 12'h014, 32'hffff_ffff);
    `CHK(err, 1'b1)
    $display("test bus done");
  endtask : t_bus
  task automatic t_erase();
    int n;
    apb(1'b1, pmlock_pkg::PMLOCK_CTRL_OFS, 32'h1);
    n = 0;
    do begin
      apb(1'b0, pmlock_pkg::PMLOCK_STAT_OFS, 32'h0);
      n++;
    end while (rd[3] !== 1'b0 && n < 400);
    `CHK(rd[3], 1'b0)
    `CHK(rd[1:0], 2'b00)
    vfy(u_prog.M_VER, 16'h0005);
    `CHK(q, 8'hff)
    $display("test erase done");
  endtask : t_erase
  task automatic t_enc();
    u_prog.prog_op(u_prog.M_CODE, 16'h0005, 8'h3a);
    u_prog.prog_op(u_prog.M_CODE, 16'h0025, 8'hc5);
    vfy(u_prog.M_VER, 16'h0005);
    `CHK(q, 8'h3a)
    u_prog.prog_op(u_prog.M_ENC, 16'h0005, 8'h96);
    vfy(u_prog.M_VER, 16'h0005);
    `CHK(q, ~(8'h3a ^ 8'h96))
    vfy(u_prog.M_VER, 16'h0025);
    `CHK(q, ~(8'hc5 ^ 8'h96))
    tr_ext <= 1'b1;
    apb(1'b1, pmlock_pkg::PMLOCK_ADDR_OFS, 32'h5);
    apb(1'b0, pmlock_pkg::PMLOCK_DATA_OFS, 32'h0);
    `CHK(rd[7:0], 8'h3a)
    $display("test encryption done");
  endtask : t_enc
  task automatic t_sig();
    vfy(u_prog.M_SIG, pmlock_pkg::PMLOCK_SIG_MAKER_ADDR);
    `CHK(q, SIGM)
    vfy(u_prog.M_SIG, pmlock_pkg::PMLOCK_SIG_PART_ADDR);
    `CHK(q, SIGP)
    $display("test signature done");
  endtask : t_sig
  task automatic t_lock1();
    ea_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    `CHK(ea_eff, 1'b0)
    ea_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    u_prog.prog_op(u_prog.M_LB1, 16'h0000, 8'h00);
    ea_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    `CHK(ea_eff, 1'b1)
    u_prog.prog_op(u_prog.M_CODE, 16'h0006, 8'h00);
    apb(1'b0, pmlock_pkg::PMLOCK_STAT_OFS, 32'h0);
    `CHK(rd[4:0], 5'b10101)
    vfy(u_prog.M_VER, 16'h0006);
    `CHK(q, 8'hff)
    apb(1'b0, pmlock_pkg::PMLOCK_DATA_OFS, 32'h0);
    `CHK(rd, 32'h0)
    tr_ext <= 1'b0;
    apb(1'b0, pmlock_pkg::PMLOCK_DATA_OFS, 32'h0);
    `CHK(rd[7:0], 8'h3a)
    ea_pin <= 1'b1;
    $display("test lock one done");
  endtask : t_lock1
  task automatic t_lock2();
    u_prog.prog_op(u_prog.M_LB2, 16'h0000, 8'h00);
    apb(1'b0, pmlock_pkg::PMLOCK_STAT_OFS, 32'h0);
    `CHK(rd[1:0], 2'b11)
    vfy(u_prog.M_VER, 16'h0005);
    `CHK({oe, q}, {1'b0, 8'hff})
    $display("test lock two done");
  endtask : t_lock2
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  // ------
  // Sequence
  // ------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, tr_ext} = '0;
    ea_pin = 1'b1;
    n_fail = 0;
    n_tests = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_bus();
    t_erase();
    t_enc();
    t_sig();
    t_lock1();
    t_lock2();
    t_erase();
    final_report();
  end
  // Two erases of 256 cycles plus pin work stay well below this span
  initial begin
    #300000;
    n_fail++;
    final_report();
  end
endmodule : test_pmlock_top
`default_nettype wire
